// ### src/dsp_mac_pkg.sv
// constants, types and register map of the mac accumulator datapath
package dsp_mac_pkg;
    // register byte addresses
    localparam logic [3:0] ADDR_CORE = 4'h0;
    localparam logic [3:0] ADDR_TRAP = 4'h4;
    localparam logic [3:0] ADDR_STAT = 4'h8;
    // core control fields
    localparam int CC_SIGN = 12;
    localparam int CC_EXIT = 11;
    localparam int CC_DEPTH = 8;
    localparam int CC_CLIP1 = 7;
    localparam int CC_CLIP2 = 6;
    localparam int CC_STCLIP = 5;
    localparam int CC_WIDTH = 4;
    localparam int CC_PTOP = 3;
    localparam int CC_INT = 0;
    localparam logic [15:0] CC_RESET = 16'h0020;
    localparam logic [15:0] CC_WMASK = 16'h10f7;
    // trap control fields
    localparam int TC_CAT = 8;
    localparam int TC_G1 = 10;
    localparam int TC_G2 = 9;
    localparam logic [15:0] TC_RESET = 16'h0000;
    // status fields
    localparam int ST_G1 = 0;
    localparam int ST_G2 = 1;
    localparam int ST_C1 = 2;
    localparam int ST_C2 = 3;
    localparam int ST_GANY = 4;
    localparam int ST_CANY = 5;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    localparam logic [39:0] MAX40 = 40'h7fffffffff;
    localparam logic [39:0] MIN40 = 40'h8000000000;
    localparam logic [39:0] MAX32 = 40'h007fffffff;
    localparam logic [39:0] MIN32 = 40'hff80000000;
    localparam logic [15:0] MAX16 = 16'h7fff;
    localparam logic [15:0] MIN16 = 16'h8000;

    typedef enum logic [2:0] {
        OP_MAC, OP_ADD, OP_SUB, OP_LOAD, OP_STORE, OP_MUL
    } op_kind_e;

    typedef struct packed {
        op_kind_e kind;
        logic acc_sel;
        logic zero_acc;
        logic carry;
        logic signed [5:0] shift;
        logic byte_size;
        logic mul_signed;
        logic [15:0] op_a;
        logic [15:0] op_b;
        logic [39:0] data;
    } dsp_op_s;
endpackage

// ### src/dsp_mac_accumulator_datapath.sv
// fixed-point multiply-accumulate datapath with axi4-lite control registers
`timescale 1ns/1ps
module dsp_mac_accumulator_datapath (
    // clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // axi4-lite write
    input wire logic s_axi_awvalid_in,
    input wire logic [3:0] s_axi_awaddr_in,
    output logic s_axi_awready_out,
    input wire logic s_axi_wvalid_in,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    output logic s_axi_wready_out,
    output logic s_axi_bvalid_out,
    output logic [1:0] s_axi_bresp_out,
    input wire logic s_axi_bready_in,
    // axi4-lite read
    input wire logic s_axi_arvalid_in,
    input wire logic [3:0] s_axi_araddr_in,
    output logic s_axi_arready_out,
    output logic s_axi_rvalid_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    input wire logic s_axi_rready_in,
    // decode side
    input wire logic op_valid_in,
    input wire dsp_mac_pkg::dsp_op_s op_in,
    input wire logic [2:0] loop_depth_in,
    input wire logic [2:0] cpu_priority_level_field_in,
    input wire logic prio_raise_in,
    // results
    output logic [39:0] accumulator_one_out,
    output logic [39:0] accumulator_two_out,
    output logic store_valid_out,
    output logic [15:0] store_data_out,
    output logic mul_valid_out,
    output logic [31:0] mul_result_out,
    output logic [4:0] flags_out,
    output logic [3:0] cpu_priority_out,
    output logic loop_exit_out,
    output logic arith_trap_out
);
    logic [15:0] core_ff;
    logic [15:0] trap_ff;
    logic prio_top_ff;
    logic [39:0] acc_ff [2];
    logic [1:0] guard_ff;
    logic [1:0] clip_ff;
    logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic [3:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [31:0] rdata_ff;
    logic store_valid_ff, mul_valid_ff, loop_exit_ff, arith_trap_ff;
    logic [15:0] store_data_ff;
    logic [31:0] mul_ff;

    // register bus
    logic do_wr;
    logic wr_hit;
    logic [15:0] wval;
    logic [31:0] rd_val;
    logic rd_hit;
    assign do_wr = !awready_ff && !wready_ff && !bvalid_ff;
    assign wr_hit = awaddr_ff == dsp_mac_pkg::ADDR_CORE || awaddr_ff == dsp_mac_pkg::ADDR_TRAP
        || awaddr_ff == dsp_mac_pkg::ADDR_STAT;
    assign wval = wdata_ff[15:0];

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
            bvalid_ff <= 1'b0;
            bresp_ff <= dsp_mac_pkg::RESP_OKAY;
            awaddr_ff <= 4'h0;
            wdata_ff <= 32'h0;
            wstrb_ff <= 4'h0;
        end else begin
            if (s_axi_awvalid_in && awready_ff) begin
                awready_ff <= 1'b0;
                awaddr_ff <= s_axi_awaddr_in;
            end
            if (s_axi_wvalid_in && wready_ff) begin
                wready_ff <= 1'b0;
                wdata_ff <= s_axi_wdata_in;
                wstrb_ff <= s_axi_wstrb_in;
            end
            if (do_wr) begin
                awready_ff <= 1'b1;
                wready_ff <= 1'b1;
                bvalid_ff <= 1'b1;
                bresp_ff <= wr_hit ? dsp_mac_pkg::RESP_OKAY : dsp_mac_pkg::RESP_SLVERR;
            end else if (bvalid_ff && s_axi_bready_in) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    always_comb begin
        rd_hit = 1'b1;
        rd_val = 32'h0;
        unique case (s_axi_araddr_in)
            dsp_mac_pkg::ADDR_CORE: begin
                rd_val[15:0] = core_ff;
                rd_val[dsp_mac_pkg::CC_DEPTH +: 3] = loop_depth_in;
                rd_val[dsp_mac_pkg::CC_PTOP] = prio_top_ff;
            end
            dsp_mac_pkg::ADDR_TRAP: rd_val[15:0] = trap_ff;
            dsp_mac_pkg::ADDR_STAT: rd_val[5:0] = {|clip_ff, |guard_ff, clip_ff, guard_ff};
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0;
            rresp_ff <= dsp_mac_pkg::RESP_OKAY;
        end else if (s_axi_arvalid_in && arready_ff) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_val; // exit bit is never stored, so it reads 0
            rresp_ff <= rd_hit ? dsp_mac_pkg::RESP_OKAY : dsp_mac_pkg::RESP_SLVERR;
        end else if (rvalid_ff && s_axi_rready_in) begin
            rvalid_ff <= 1'b0;
            arready_ff <= 1'b1;
        end
    end

    // control registers
    logic wr_core, wr_trap, wr_stat;
    logic [15:0] lane_mask;
    assign lane_mask = {{8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
    assign wr_core = do_wr && awaddr_ff == dsp_mac_pkg::ADDR_CORE;
    assign wr_trap = do_wr && awaddr_ff == dsp_mac_pkg::ADDR_TRAP;
    assign wr_stat = do_wr && awaddr_ff == dsp_mac_pkg::ADDR_STAT && wstrb_ff[0];

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            core_ff <= dsp_mac_pkg::CC_RESET;
            trap_ff <= dsp_mac_pkg::TC_RESET;
        end else begin
            if (wr_core) begin
                core_ff <= (core_ff & ~(dsp_mac_pkg::CC_WMASK & lane_mask))
                    | (wval & dsp_mac_pkg::CC_WMASK & lane_mask);
            end
            if (wr_trap) begin
                trap_ff <= (trap_ff & ~lane_mask) | (wval & lane_mask);
            end
        end
    end

    // a write of 1 only gives a pulse; decode finishes the current iteration
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            loop_exit_ff <= 1'b0;
        end else begin
            loop_exit_ff <= wr_core && wstrb_ff[1] && wval[dsp_mac_pkg::CC_EXIT];
        end
    end

    // hardware raise beats a software clear in the same cycle
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            prio_top_ff <= 1'b0;
        end else if (prio_raise_in) begin
            prio_top_ff <= 1'b1;
        end else if (wr_core && wstrb_ff[0] && !wval[dsp_mac_pkg::CC_PTOP]) begin
            prio_top_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            cpu_priority_out <= 4'h0;
        end else begin
            cpu_priority_out <= {prio_top_ff, cpu_priority_level_field_in};
        end
    end

    // multiplier
    logic us_mode, int_mode;
    logic signed [16:0] ma, mb;
    logic signed [33:0] prod;
    logic [32:0] scaled;
    logic signed [39:0] mul40;
    assign us_mode = core_ff[dsp_mac_pkg::CC_SIGN];
    assign int_mode = core_ff[dsp_mac_pkg::CC_INT];

    always_comb begin
        if (op_in.kind == dsp_mac_pkg::OP_MUL) begin
            ma = op_in.byte_size ? {{9{op_in.mul_signed & op_in.op_a[7]}}, op_in.op_a[7:0]}
                : {op_in.mul_signed & op_in.op_a[15], op_in.op_a};
            mb = op_in.byte_size ? {{9{op_in.mul_signed & op_in.op_b[7]}}, op_in.op_b[7:0]}
                : {op_in.mul_signed & op_in.op_b[15], op_in.op_b};
        end else begin
            ma = {!us_mode & op_in.op_a[15], op_in.op_a};
            mb = {!us_mode & op_in.op_b[15], op_in.op_b};
        end
    end

    assign prod = ma * mb;
    // fractional drops the duplicate sign bit to left-align 1.31
    assign scaled = int_mode ? prod[32:0] : {prod[31:0], 1'b0};
    assign mul40 = {{7{scaled[32]}}, scaled};

    // adder and saturation
    logic sel;
    logic [39:0] acc_cur, shifted, xin, yin, res, clip_val;
    logic [40:0] sum;
    logic cat, guard, ovf, sat_en, wide, true_neg, is_sub;
    assign sel = op_in.acc_sel;
    assign acc_cur = acc_ff[sel];
    assign is_sub = op_in.kind == dsp_mac_pkg::OP_SUB;
    assign sat_en = sel ? core_ff[dsp_mac_pkg::CC_CLIP2] : core_ff[dsp_mac_pkg::CC_CLIP1];
    assign wide = core_ff[dsp_mac_pkg::CC_WIDTH];

    always_comb begin
        if (op_in.shift < 0) begin
            shifted = 40'($signed(op_in.data) >>> (-op_in.shift));
        end else begin
            shifted = op_in.data << op_in.shift;
        end
    end

    always_comb begin
        xin = op_in.kind == dsp_mac_pkg::OP_MAC ? mul40 : shifted;
        if (is_sub) begin
            xin = ~xin;
        end
        yin = (op_in.zero_acc || op_in.kind == dsp_mac_pkg::OP_LOAD) ? 40'h0 : acc_cur;
    end

    // carry input is taken as given: high adds one, low borrows on subtract
    assign sum = {yin[39], yin} + {xin[39], xin} + {40'h0, op_in.carry};
    assign res = sum[39:0];
    assign cat = sum[40] ^ sum[39];
    assign guard = !(&res[39:32] || !(|res[39:32]));
    assign true_neg = sum[40];

    always_comb begin
        if (wide) begin
            ovf = cat;
            clip_val = true_neg ? dsp_mac_pkg::MIN40 : dsp_mac_pkg::MAX40;
        end else begin
            ovf = cat || !(&res[39:31] || !(|res[39:31]));
            clip_val = true_neg ? dsp_mac_pkg::MIN32 : dsp_mac_pkg::MAX32;
        end
        if (!sat_en) begin
            ovf = cat;
        end
    end

    logic acc_op;
    assign acc_op = op_valid_in && (op_in.kind == dsp_mac_pkg::OP_MAC
        || op_in.kind == dsp_mac_pkg::OP_ADD || is_sub
        || op_in.kind == dsp_mac_pkg::OP_LOAD);

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            acc_ff[0] <= 40'h0;
            acc_ff[1] <= 40'h0;
        end else if (acc_op) begin
            acc_ff[sel] <= (sat_en && ovf) ? clip_val : res;
        end
    end

    // guard flags follow every adder pass of their accumulator
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            guard_ff <= 2'b00;
        end else if (acc_op) begin
            guard_ff[sel] <= guard;
        end
    end

    // clip flags: a set in the clearing cycle wins
    logic [1:0] clip_clr;
    assign clip_clr = wr_stat ? {wval[dsp_mac_pkg::ST_C2], wval[dsp_mac_pkg::ST_C1]} : 2'b00;
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_clip
            always_ff @(posedge clk_in) begin
                if (sys_rst_in) begin
                    clip_ff[gi] <= 1'b0;
                end else if (acc_op && sel == gi && ovf) begin
                    clip_ff[gi] <= 1'b1;
                end else if (clip_clr[gi]) begin
                    clip_ff[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // traps fire on the pass that sets the flag
    logic trap_now;
    assign trap_now = acc_op && ((guard && (sel ? trap_ff[dsp_mac_pkg::TC_G2]
        : trap_ff[dsp_mac_pkg::TC_G1]))
        || (!sat_en && ovf && trap_ff[dsp_mac_pkg::TC_CAT]));

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            arith_trap_ff <= 1'b0;
        end else begin
            arith_trap_ff <= trap_now;
        end
    end

    // store and general multiply
    logic [39:0] st_acc;
    logic st_ovf;
    assign st_acc = acc_ff[sel];
    assign st_ovf = !(&st_acc[39:31] || !(|st_acc[39:31]));
    logic [15:0] st_mid;
    assign st_mid = st_acc[31:16];

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            store_valid_ff <= 1'b0;
            store_data_ff <= 16'h0;
        end else begin
            store_valid_ff <= op_valid_in && op_in.kind == dsp_mac_pkg::OP_STORE;
            if (op_valid_in && op_in.kind == dsp_mac_pkg::OP_STORE) begin
                if (core_ff[dsp_mac_pkg::CC_STCLIP] && st_ovf) begin
                    store_data_ff <= st_acc[39] ? dsp_mac_pkg::MIN16 : dsp_mac_pkg::MAX16;
                end else begin
                    store_data_ff <= st_acc[31:16];
                end
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            mul_valid_ff <= 1'b0;
            mul_ff <= 32'h0;
        end else begin
            mul_valid_ff <= op_valid_in && op_in.kind == dsp_mac_pkg::OP_MUL;
            if (op_valid_in && op_in.kind == dsp_mac_pkg::OP_MUL) begin
                mul_ff <= op_in.byte_size ? {16'h0, prod[15:0]} : prod[31:0];
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            flags_out <= 5'h0;
        end else begin
            // clip any must agree with the clip bits shown beside it, set-wins included
            flags_out <= {|clip_ff, |guard_ff, clip_ff, guard_ff[0]};
        end
    end

    assign s_axi_awready_out = awready_ff;
    assign s_axi_wready_out = wready_ff;
    assign s_axi_bvalid_out = bvalid_ff;
    assign s_axi_bresp_out = bresp_ff;
    assign s_axi_arready_out = arready_ff;
    assign s_axi_rvalid_out = rvalid_ff;
    assign s_axi_rdata_out = rdata_ff;
    assign s_axi_rresp_out = rresp_ff;
    assign accumulator_one_out = acc_ff[0];
    assign accumulator_two_out = acc_ff[1];
    assign store_valid_out = store_valid_ff;
    assign store_data_out = store_data_ff;
    assign mul_valid_out = mul_valid_ff;
    assign mul_result_out = mul_ff;
    assign loop_exit_out = loop_exit_ff;
    assign arith_trap_out = arith_trap_ff;

    // checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    sequence s_wr_taken;
        do_wr;
    endsequence
    sequence s_resp;
        ##1 bvalid_ff;
    endsequence

    property p_wr_resp;
        s_wr_taken |-> s_resp;
    endproperty
    a_wr_resp: assert property (p_wr_resp) else $error("write response missing");

    property p_exit_zero;
        s_axi_arvalid_in && arready_ff && s_axi_araddr_in == dsp_mac_pkg::ADDR_CORE
            |=> !rdata_ff[dsp_mac_pkg::CC_EXIT];
    endproperty
    a_exit_zero: assert property (p_exit_zero) else $error("exit bit read nonzero");

    property p_clip_sticky;
        $fell(clip_ff[0]) |-> $past(clip_clr[0]);
    endproperty
    a_clip_sticky: assert property (p_clip_sticky) else $error("clip flag self cleared");

    property p_guard_tracks;
        acc_op && !sel |=> guard_ff[0] == !(&acc_ff[0][39:32] || !(|acc_ff[0][39:32]))
            || clip_ff[0];
    endproperty
    a_guard_tracks: assert property (p_guard_tracks) else $error("guard flag wrong");

    property p_any_or;
        ##1 flags_out[3] == ($past(guard_ff) != 2'b00);
    endproperty
    a_any_or: assert property (p_any_or) else $error("any guard flag wrong");

    property p_guard_trap;
        acc_op && guard && !sel && trap_ff[dsp_mac_pkg::TC_G1] |=> arith_trap_out;
    endproperty
    a_guard_trap: assert property (p_guard_trap) else $error("guard trap missing");

    property p_prio_top;
        $rose(prio_top_ff) |-> $past(prio_raise_in);
    endproperty
    a_prio_top: assert property (p_prio_top) else $error("priority top set by software");

    property p_sat32;
        acc_op && !sel && sat_en && !wide |=> &acc_ff[0][39:31] || !(|acc_ff[0][39:31]);
    endproperty
    a_sat32: assert property (p_sat32) else $error("32-bit clip exceeded");

    property p_store_raw;
        op_valid_in && op_in.kind == dsp_mac_pkg::OP_STORE
            && !core_ff[dsp_mac_pkg::CC_STCLIP] |=> store_data_out == $past(st_mid);
    endproperty
    a_store_raw: assert property (p_store_raw) else $error("unclipped store altered");
endmodule

// ### bench/dsp_decode_model.sv
// behavioural model of the instruction decode feeding the mac datapath
`timescale 1ns/1ps
module dsp_decode_model (
    // clock
    input wire logic clk_in,
    // decode side
    output logic op_valid_out,
    output dsp_mac_pkg::dsp_op_s op_out,
    output logic [2:0] loop_depth_out,
    output logic [2:0] prio_level_out,
    output logic prio_raise_out
);
    initial begin
        op_valid_out = 1'b0;
        op_out = '0;
        loop_depth_out = 3'h5;
        prio_level_out = 3'h0;
        prio_raise_out = 1'b0;
    end

    // one op per call; the payload is scrambled once released so stale data is never reused
    task automatic issue(input dsp_mac_pkg::dsp_op_s op);
        @(posedge clk_in);
        op_valid_out <= 1'b1;
        op_out <= op;
        @(posedge clk_in);
        op_valid_out <= 1'b0;
        op_out <= dsp_mac_pkg::dsp_op_s'(~op);
    endtask

    task automatic raise(input logic [2:0] lvl);
        @(posedge clk_in);
        prio_level_out <= lvl;
        prio_raise_out <= 1'b1;
        @(posedge clk_in);
        prio_raise_out <= 1'b0;
    endtask
endmodule

// ### bench/dsp_mac_accumulator_datapath_tb.sv
// self-checking bench of the mac accumulator datapath
`timescale 1ns/1ps
module dsp_mac_accumulator_datapath_tb;
    logic clk_in, sys_rst_in, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, op_valid, prio_raise;
    logic [3:0] awaddr, araddr, wstrb, prio;
    logic [31:0] wdata, rdata, mul_result, last_mul;
    logic [1:0] bresp, rresp;
    logic [2:0] depth, plevel;
    logic [39:0] acc1, acc2;
    logic store_valid, mul_valid, loop_exit, trap;
    logic [15:0] store_data, last_store;
    logic [4:0] flags;
    dsp_mac_pkg::dsp_op_s op;
    int err_total = 0;
    int checks = 0;
    int trap_cnt = 0;
    int exit_cnt = 0;
    int t0;

    dsp_mac_accumulator_datapath DUT (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .s_axi_awvalid_in(awvalid), .s_axi_awaddr_in(awaddr), .s_axi_awready_out(awready),
        .s_axi_wvalid_in(wvalid), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb),
        .s_axi_wready_out(wready), .s_axi_bvalid_out(bvalid), .s_axi_bresp_out(bresp),
        .s_axi_bready_in(bready), .s_axi_arvalid_in(arvalid), .s_axi_araddr_in(araddr),
        .s_axi_arready_out(arready), .s_axi_rvalid_out(rvalid), .s_axi_rdata_out(rdata),
        .s_axi_rresp_out(rresp), .s_axi_rready_in(rready), .op_valid_in(op_valid),
        .op_in(op), .loop_depth_in(depth), .cpu_priority_level_field_in(plevel),
        .prio_raise_in(prio_raise), .accumulator_one_out(acc1), .accumulator_two_out(acc2),
        .store_valid_out(store_valid), .store_data_out(store_data),
        .mul_valid_out(mul_valid), .mul_result_out(mul_result), .flags_out(flags),
        .cpu_priority_out(prio), .loop_exit_out(loop_exit), .arith_trap_out(trap));

    dsp_decode_model DEC (.clk_in(clk_in), .op_valid_out(op_valid), .op_out(op),
        .loop_depth_out(depth), .prio_level_out(plevel), .prio_raise_out(prio_raise));

    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end

    // pulses are caught here so checks need not hit their exact cycle
    always @(posedge clk_in) begin
        if (trap === 1'b1) trap_cnt <= trap_cnt + 1;
        if (loop_exit === 1'b1) exit_cnt <= exit_cnt + 1;
        if (store_valid === 1'b1) last_store <= store_data;
        if (mul_valid === 1'b1) last_mul <= mul_result;
    end

    task automatic report_and_stop();
        $display("errors %0d checks %0d", err_total, checks);
        if (err_total == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic [1:0] er);
        @(posedge clk_in);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= {16'h0000, d};
        wstrb <= 4'hf;
        bready <= 1'b1;
        // only the watchdog ends a wait that never sees the response
        do begin
            @(posedge clk_in);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk(40'({bvalid, bresp}), 40'({1'b1, er}));
    endtask

    task automatic rd(input logic [3:0] a, input logic [15:0] ed, input logic [1:0] er);
        @(posedge clk_in);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do begin
            @(posedge clk_in);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk(40'({rvalid, rresp}), 40'({1'b1, er}));
        if (er === dsp_mac_pkg::RESP_OKAY) chk(40'(rdata), 40'(ed));
    endtask

    task automatic run(input dsp_mac_pkg::op_kind_e k, input logic s, input logic [39:0] d,
                       input logic [15:0] a = 16'h0, input logic [15:0] b = 16'h0,
                       input logic bs = 1'b0, input logic ms = 1'b0, input logic [5:0] sh = 6'h0);
        dsp_mac_pkg::dsp_op_s o;
        o = '0;
        o.kind = k;
        o.acc_sel = s;
        o.zero_acc = (k == dsp_mac_pkg::OP_LOAD);
        o.carry = (k == dsp_mac_pkg::OP_SUB);
        o.shift = sh;
        o.data = d;
        o.op_a = a;
        o.op_b = b;
        o.byte_size = bs;
        o.mul_signed = ms;
        DEC.issue(o);
        repeat (3) @(posedge clk_in);
    endtask

    initial begin
        #40000;
        err_total++;
        report_and_stop();
    end

    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        awaddr = 4'h0;
        araddr = 4'h0;
        wdata = 32'h0;
        wstrb = 4'h0;
        sys_rst_in = 1'b1;
        repeat (8) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        rd(dsp_mac_pkg::ADDR_CORE, 16'h0520, dsp_mac_pkg::RESP_OKAY);
        rd(dsp_mac_pkg::ADDR_TRAP, 16'h0000, dsp_mac_pkg::RESP_OKAY);
        rd(4'hc, 16'h0, dsp_mac_pkg::RESP_SLVERR);
        wr(4'hc, 16'hffff, dsp_mac_pkg::RESP_SLVERR);
        wr(dsp_mac_pkg::ADDR_CORE, 16'h0f28, dsp_mac_pkg::RESP_OKAY);
        rd(dsp_mac_pkg::ADDR_CORE, 16'h0520, dsp_mac_pkg::RESP_OKAY);
        chk(40'(exit_cnt > 0), 40'h1);
        DEC.raise(3'h6);
        repeat (3) @(posedge clk_in);
        chk(40'(prio), 40'he);
        wr(dsp_mac_pkg::ADDR_CORE, 16'h0020, dsp_mac_pkg::RESP_OKAY);
        repeat (3) @(posedge clk_in);
        chk(40'(prio), 40'h6);
        run(dsp_mac_pkg::OP_MUL, 1'b0, 40'h0, 16'hffff, 16'h0002, 1'b0, 1'b1);
        chk(40'(last_mul), 40'hfffffffe);
        run(dsp_mac_pkg::OP_MUL, 1'b0, 40'h0, 16'hffff, 16'h0002, 1'b0, 1'b0);
        chk(40'(last_mul), 40'h0001fffe);
        run(dsp_mac_pkg::OP_MUL, 1'b0, 40'h0, 16'h00ff, 16'h00ff, 1'b1, 1'b0);
        chk(40'(last_mul), 40'h0000fe01);
        run(dsp_mac_pkg::OP_MAC, 1'b0, 40'h0, 16'h8000, 16'h8000);
        chk(acc1, 40'h0080000000);
        run(dsp_mac_pkg::OP_STORE, 1'b0, 40'h0);
        chk(40'(last_store), 40'h7fff);
        wr(dsp_mac_pkg::ADDR_CORE, 16'h1001, dsp_mac_pkg::RESP_OKAY);
        run(dsp_mac_pkg::OP_STORE, 1'b0, 40'h0);
        chk(40'(last_store), 40'h8000);
        run(dsp_mac_pkg::OP_MAC, 1'b1, 40'h0, 16'hffff, 16'hffff);
        chk(acc2, 40'h00fffe0001);
        wr(dsp_mac_pkg::ADDR_CORE, 16'h0001, dsp_mac_pkg::RESP_OKAY);
        run(dsp_mac_pkg::OP_MAC, 1'b1, 40'h0, 16'hffff, 16'hffff);
        chk(acc2, 40'h00fffe0002);
        wr(dsp_mac_pkg::ADDR_CORE, 16'h0020, dsp_mac_pkg::RESP_OKAY);
        run(dsp_mac_pkg::OP_LOAD, 1'b1, 40'h3, 16'h0, 16'h0, 1'b0, 1'b0, 6'h02);
        chk(acc2, 40'hc);
        wr(dsp_mac_pkg::ADDR_TRAP, 16'h0400, dsp_mac_pkg::RESP_OKAY);
        t0 = trap_cnt;
        run(dsp_mac_pkg::OP_LOAD, 1'b0, 40'h0100000000);
        chk(40'(trap_cnt > t0), 40'h1);
        chk(40'({flags[3], flags[0]}), 40'h3);
        rd(dsp_mac_pkg::ADDR_STAT, 16'h0011, dsp_mac_pkg::RESP_OKAY);
        run(dsp_mac_pkg::OP_SUB, 1'b0, 40'h0100000000);
        chk(acc1, 40'h0);
        rd(dsp_mac_pkg::ADDR_STAT, 16'h0000, dsp_mac_pkg::RESP_OKAY);
        wr(dsp_mac_pkg::ADDR_CORE, 16'h00a0, dsp_mac_pkg::RESP_OKAY);
        run(dsp_mac_pkg::OP_ADD, 1'b0, 40'h0080000000);
        chk(acc1, dsp_mac_pkg::MAX32);
        chk(40'(flags), 40'h12);
        rd(dsp_mac_pkg::ADDR_STAT, 16'h0024, dsp_mac_pkg::RESP_OKAY);
        run(dsp_mac_pkg::OP_LOAD, 1'b0, 40'h0);
        run(dsp_mac_pkg::OP_SUB, 1'b0, 40'h0080000001);
        chk(acc1, dsp_mac_pkg::MIN32);
        rd(dsp_mac_pkg::ADDR_STAT, 16'h0024, dsp_mac_pkg::RESP_OKAY);
        wr(dsp_mac_pkg::ADDR_STAT, 16'h0004, dsp_mac_pkg::RESP_OKAY);
        rd(dsp_mac_pkg::ADDR_STAT, 16'h0000, dsp_mac_pkg::RESP_OKAY);
        wr(dsp_mac_pkg::ADDR_CORE, 16'h0070, dsp_mac_pkg::RESP_OKAY);
        run(dsp_mac_pkg::OP_LOAD, 1'b1, dsp_mac_pkg::MAX40);
        run(dsp_mac_pkg::OP_ADD, 1'b1, 40'h1);
        chk(acc2, dsp_mac_pkg::MAX40);
        rd(dsp_mac_pkg::ADDR_STAT, 16'h003a, dsp_mac_pkg::RESP_OKAY);
        wr(dsp_mac_pkg::ADDR_STAT, 16'h0008, dsp_mac_pkg::RESP_OKAY);
        wr(dsp_mac_pkg::ADDR_TRAP, 16'h0100, dsp_mac_pkg::RESP_OKAY);
        wr(dsp_mac_pkg::ADDR_CORE, 16'h0020, dsp_mac_pkg::RESP_OKAY);
        run(dsp_mac_pkg::OP_LOAD, 1'b1, dsp_mac_pkg::MAX40);
        t0 = trap_cnt;
        run(dsp_mac_pkg::OP_ADD, 1'b1, 40'h1);
        chk(acc2, dsp_mac_pkg::MIN40);
        chk(40'(trap_cnt > t0), 40'h1);
        rd(dsp_mac_pkg::ADDR_STAT, 16'h003a, dsp_mac_pkg::RESP_OKAY);
        chk(40'(flags), 40'h1c);
        report_and_stop();
    end
endmodule
